/* src/ctr_record_logic.sv */
// Connection table record logic: sticky flags and lookup record decode

// Function
// (RL1) Flag word: egress 31:28, ingress 15:12
// (RL2) End-to-end AIS sets alarm flag
// (RL3) End-to-end RDI sets remote-defect flag
// (RL4) User or any CC sets segment flag
// (RL5) User or end-to-end CC sets e2e flag
// (RL6) Flags sticky; only processor write clears; back-to-back events on one record drop the first event's sets
// (RL7) Processor reads active flag records periodically
// (RL8) VP table holds up to 4K records
// (RL9) No VC lookup: packed halves, else word
// (RL10) Mode 01 or 11 skips VC lookup
// (RL11) Data order selects which half is even
// (RL12) All-ones identifier in VP/VC invalid
// (RL13) Upper half all ones: VP switching
// (RL14) Otherwise offset plus base locates sub-table
// (RL15) Masked VCI bits packed toward bit zero
// (RL16) VC record gives 16-bit ingress identifier
// (RL17) Processor initialises VC records at setup
// (RL18) Multicast index reads packed egress identifier
// (RL19) All-ones egress identifier is invalid
// (RL20) Invalid identifier: unknown, skip flag update
module ctr_record_logic
(
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          arst_n,
    // Configuration
    input  wire logic [1:0]                    addr_compress_mode,
    input  wire logic                          data_order_little,
    input  wire logic [ctr_pkg::ADDR_W-1:0]    vp_table_base,
    input  wire logic [ctr_pkg::ADDR_W-1:0]    vc_table_base,
    input  wire logic [ctr_pkg::ADDR_W-1:0]    mc_table_base,
    // Lookup request
    input  wire logic                          lk_valid,
    output logic                               lk_ready,
    input  wire ctr_pkg::ctr_lookup_req_t      lk_req,
    // External table memory read
    output logic                               tm_rd,
    output logic      [ctr_pkg::ADDR_W-1:0]    tm_addr,
    input  wire logic                          tm_rvalid,
    input  wire logic [31:0]                   tm_rdata,
    // Lookup result
    output logic                               rs_valid,
    output ctr_pkg::ctr_lookup_rsp_t           rs_data,
    // Cell events for flag update
    input  wire logic                          ev_valid,
    input  wire ctr_pkg::ctr_cell_ev_t         ev_data,
    input  wire logic                          ev_unknown,
    // Processor flag access
    input  wire logic                          hp_rd,
    input  wire logic                          hp_wr,
    input  wire logic [ctr_pkg::FLAG_IDX_W-1:0] hp_addr,
    input  wire logic [31:0]                   hp_wdata,
    output logic                               hp_rvalid,
    output logic      [31:0]                   hp_rdata,
    output logic                               hp_busy
);

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] pick_half(input logic [31:0] w, input logic odd, input logic little);
        logic upper;
        upper = odd ^ ~little; // RL11
        return upper ? w[31:16] : w[15:0];
    endfunction : pick_half

    function automatic logic [15:0] compress_vci(input logic [15:0] vci, input logic [15:0] mask);
        logic [15:0] r;
        int unsigned k;
        r = 16'h0000;
        k = 0;
        for (int i = 0; i < 16; i++)
        begin
            if (mask[i])
            begin
                r[k[3:0]] = vci[i]; // RL15
                k++;
            end
        end
        return r;
    endfunction : compress_vci

    function automatic logic [31:0] flag_sets(input ctr_pkg::ctr_cell_kind_t kind, input logic egress);
        logic [3:0] f;
        f = 4'h0;
        f[3] = (kind == ctr_pkg::CTR_CELL_AIS); // RL2
        f[2] = (kind == ctr_pkg::CTR_CELL_RDI); // RL3
        f[1] = (kind == ctr_pkg::CTR_CELL_USER) || (kind == ctr_pkg::CTR_CELL_CC_E2E)
               || (kind == ctr_pkg::CTR_CELL_CC_SEG); // RL4
        f[0] = (kind == ctr_pkg::CTR_CELL_USER) || (kind == ctr_pkg::CTR_CELL_CC_E2E); // RL5
        return egress ? {f, 28'h0000000} : {16'h0000, f, 12'h000}; // RL1
    endfunction : flag_sets

    // ------------------------------------------------------------
    // Lookup state machine
    // ------------------------------------------------------------
    typedef enum logic [2:0]
    {
        LK_IDLE,
        LK_VP_RD,
        LK_VP_WAIT,
        LK_VC_WAIT,
        LK_MC_WAIT,
        LK_DONE
    } ctr_lk_state_t;

    ctr_lk_state_t               state_reg;
    ctr_pkg::ctr_lookup_req_t    req_reg;
    logic [15:0]                 conn_reg;
    logic                        unk_reg;
    logic                        vc_off_reg;
    logic [ctr_pkg::ADDR_W-1:0]  addr_reg;
    logic                        rd_reg;

    logic                        vc_on;
    logic [15:0]                 vc_idx;
    logic [15:0]                 vp_upper;
    logic [15:0]                 vp_lower;

    assign vc_on    = !(addr_compress_mode == ctr_pkg::ACM_NO_VC_A
                        || addr_compress_mode == ctr_pkg::ACM_NO_VC_B); // RL10
    assign vp_upper = tm_rdata[31:16];
    assign vp_lower = tm_rdata[15:0];
    assign vc_idx   = compress_vci(req_reg.vci, vp_lower);
    assign lk_ready = (state_reg == LK_IDLE);

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg  <= LK_IDLE;
            req_reg    <= '0;
            conn_reg   <= ctr_pkg::CONN_RESET;
            unk_reg    <= 1'b0;
            vc_off_reg <= 1'b0;
            addr_reg   <= '0;
            rd_reg     <= 1'b0;
        end
        else
        begin
            rd_reg <= 1'b0;
            case (state_reg)
                LK_IDLE:
                begin
                    if (lk_valid)
                    begin
                        req_reg <= lk_req;
                        rd_reg  <= 1'b1;
                        if (lk_req.multicast)
                        begin
                            // Two records per word: word index is identifier / 2
                            addr_reg  <= mc_table_base + ctr_pkg::ADDR_W'(lk_req.mcast_id[15:1]); // RL18
                            state_reg <= LK_MC_WAIT;
                        end
                        else if (vc_on)
                        begin
                            addr_reg   <= vp_table_base + ctr_pkg::ADDR_W'(lk_req.vpi); // RL8 RL9
                            vc_off_reg <= 1'b0;
                            state_reg  <= LK_VP_WAIT;
                        end
                        else
                        begin
                            addr_reg   <= vp_table_base + ctr_pkg::ADDR_W'(lk_req.vpi[11:1]); // RL9
                            vc_off_reg <= 1'b1;
                            state_reg  <= LK_VP_WAIT;
                        end
                    end
                end
                LK_VP_WAIT:
                begin
                    if (tm_rvalid)
                    begin
                        if (vc_off_reg)
                        begin
                            conn_reg  <= pick_half(tm_rdata, req_reg.vpi[0], data_order_little); // RL11
                            unk_reg   <= (pick_half(tm_rdata, req_reg.vpi[0], data_order_little)
                                          == ctr_pkg::CONN_INVALID); // RL12
                            state_reg <= LK_DONE;
                        end
                        else if (vp_upper == ctr_pkg::VP_SWITCH_TAG)
                        begin
                            conn_reg  <= vp_lower; // RL13
                            unk_reg   <= (vp_lower == ctr_pkg::CONN_INVALID); // RL12
                            state_reg <= LK_DONE;
                        end
                        else
                        begin
                            // Sub-table offset is in words; index then halves for packed records
                            addr_reg  <= vc_table_base + ctr_pkg::ADDR_W'(vp_upper)
                                         + ctr_pkg::ADDR_W'(vc_idx[15:1]); // RL14 RL15
                            req_reg.vci <= vc_idx;
                            rd_reg    <= 1'b1;
                            state_reg <= LK_VC_WAIT;
                        end
                    end
                end
                LK_VC_WAIT:
                begin
                    if (tm_rvalid)
                    begin
                        conn_reg  <= pick_half(tm_rdata, req_reg.vci[0], data_order_little); // RL16
                        unk_reg   <= (pick_half(tm_rdata, req_reg.vci[0], data_order_little)
                                      == ctr_pkg::CONN_INVALID); // RL12
                        state_reg <= LK_DONE;
                    end
                end
                LK_MC_WAIT:
                begin
                    if (tm_rvalid)
                    begin
                        conn_reg  <= pick_half(tm_rdata, req_reg.mcast_id[0], data_order_little); // RL18
                        unk_reg   <= (pick_half(tm_rdata, req_reg.mcast_id[0], data_order_little)
                                      == ctr_pkg::CONN_INVALID); // RL19
                        state_reg <= LK_DONE;
                    end
                end
                LK_DONE:
                begin
                    state_reg <= LK_IDLE;
                end
                default:
                begin
                    state_reg <= LK_IDLE;
                end
            endcase
        end
    end

    assign tm_rd             = rd_reg;
    assign tm_addr           = addr_reg;
    assign rs_valid          = (state_reg == LK_DONE);
    assign rs_data.conn      = conn_reg;
    assign rs_data.unknown   = unk_reg; // RL20
    assign rs_data.multicast = req_reg.multicast;

    // ------------------------------------------------------------
    // Flag update pipeline
    // ------------------------------------------------------------
    // Read-modify-write over two cycles; the processor port is held off
    // while an update is in flight so a clear cannot race a set.
    logic                          up_reg;
    logic [ctr_pkg::FLAG_IDX_W-1:0] up_addr_reg;
    logic [31:0]                   up_set_reg;
    logic                          hr_reg;
    logic [31:0]                   mem_rdata;
    logic                          mem_wr;
    logic [ctr_pkg::FLAG_IDX_W-1:0] mem_waddr;
    logic [31:0]                   mem_wdata;
    logic [ctr_pkg::FLAG_IDX_W-1:0] mem_raddr;
    logic                          ev_take;

    assign ev_take = ev_valid && !ev_unknown
                     && (ev_data.conn != ctr_pkg::CONN_INVALID); // RL20
    assign hp_busy = ev_take || up_reg;
    assign mem_raddr = ev_take ? ev_data.conn[ctr_pkg::FLAG_IDX_W-1:0] : hp_addr;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            up_reg      <= 1'b0;
            up_addr_reg <= '0;
            up_set_reg  <= ctr_pkg::FLAG_RESET;
        end
        else
        begin
            up_reg      <= ev_take;
            up_addr_reg <= ev_data.conn[ctr_pkg::FLAG_IDX_W-1:0];
            up_set_reg  <= flag_sets(ev_data.kind, ev_data.egress);
        end
    end

    always_comb
    begin
        mem_wr    = 1'b0;
        mem_waddr = hp_addr;
        mem_wdata = hp_wdata & ctr_pkg::FLAG_USED_MASK; // RL1
        if (up_reg)
        begin
            mem_wr    = 1'b1;
            mem_waddr = up_addr_reg;
            mem_wdata = (mem_rdata | up_set_reg) & ctr_pkg::FLAG_USED_MASK; // RL6
        end
        else if (hp_wr && !ev_take)
        begin
            mem_wr = 1'b1; // RL6
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            hr_reg    <= 1'b0;
            hp_rvalid <= 1'b0;
            hp_rdata  <= ctr_pkg::WORD_RESET;
        end
        else
        begin
            hr_reg    <= hp_rd && !hp_busy;
            hp_rvalid <= hr_reg;
            if (hr_reg)
                hp_rdata <= mem_rdata & ctr_pkg::FLAG_USED_MASK;
        end
    end

    ctr_flag_mem u_flag_mem
    (
        .clk     (clk),
        .rd_addr (mem_raddr),
        .rd_data (mem_rdata),
        .wr_en   (mem_wr),
        .wr_addr (mem_waddr),
        .wr_data (mem_wdata)
    );

endmodule : ctr_record_logic

/* inc/ctr_pkg.sv */
// Package: shared constants and types for the connection table record logic
package ctr_pkg;

    // ------------------------------------------------------------
    // Widths and table sizes
    // ------------------------------------------------------------
    localparam int unsigned CONN_W      = 16;
    localparam int unsigned ADDR_W      = 20;
    localparam int unsigned VP_ENTRIES  = 4096;
    localparam int unsigned VP_IDX_W    = 12;
    localparam int unsigned FLAG_DEPTH  = 256;
    localparam int unsigned FLAG_IDX_W  = 8;

    // ------------------------------------------------------------
    // Flag record field positions
    // ------------------------------------------------------------
    localparam int unsigned EG_ALARM_BIT   = 31;
    localparam int unsigned EG_RDI_BIT     = 30;
    localparam int unsigned EG_SEG_BIT     = 29;
    localparam int unsigned EG_E2E_BIT     = 28;
    localparam int unsigned IN_ALARM_BIT   = 15;
    localparam int unsigned IN_RDI_BIT     = 14;
    localparam int unsigned IN_SEG_BIT     = 13;
    localparam int unsigned IN_E2E_BIT     = 12;
    localparam logic [31:0] FLAG_USED_MASK = 32'hF000_F000;
    localparam logic [31:0] FLAG_RESET     = 32'h0000_0000;

    // ------------------------------------------------------------
    // Lookup encodings
    // ------------------------------------------------------------
    localparam logic [15:0] CONN_INVALID   = 16'hFFFF;
    localparam logic [15:0] VP_SWITCH_TAG  = 16'hFFFF;
    localparam logic [1:0]  ACM_NO_VC_A    = 2'h1;
    localparam logic [1:0]  ACM_NO_VC_B    = 2'h3;
    localparam logic [31:0] WORD_RESET     = 32'h0000_0000;
    localparam logic [15:0] CONN_RESET     = 16'h0000;

    // ------------------------------------------------------------
    // Cell kinds and lookup request types
    // ------------------------------------------------------------
    typedef enum logic [2:0]
    {
        CTR_CELL_USER,
        CTR_CELL_AIS,
        CTR_CELL_RDI,
        CTR_CELL_CC_E2E,
        CTR_CELL_CC_SEG,
        CTR_CELL_OTHER
    } ctr_cell_kind_t;

    typedef struct packed
    {
        logic           egress;
        ctr_cell_kind_t kind;
        logic [15:0]    conn;
    } ctr_cell_ev_t;

    typedef struct packed
    {
        logic        multicast;
        logic [11:0] vpi;
        logic [15:0] vci;
        logic [15:0] mcast_id;
    } ctr_lookup_req_t;

    typedef struct packed
    {
        logic [15:0] conn;
        logic        unknown;
        logic        multicast;
    } ctr_lookup_rsp_t;

endpackage : ctr_pkg

/* src/ctr_flag_mem.sv */
// Flag record memory: 256 words indexed by connection low bits, registered read data
module ctr_flag_mem
(
    // Clock
    input  wire logic                              clk,
    // Port A: read
    input  wire logic [ctr_pkg::FLAG_IDX_W-1:0]   rd_addr,
    output logic      [31:0]                       rd_data,
    // Port B: write
    input  wire logic                              wr_en,
    input  wire logic [ctr_pkg::FLAG_IDX_W-1:0]   wr_addr,
    input  wire logic [31:0]                       wr_data
);

    logic [31:0] mem [ctr_pkg::FLAG_DEPTH];

    always_ff @(posedge clk)
    begin
        if (wr_en)
            mem[wr_addr] <= wr_data;
    end

    always_ff @(posedge clk)
    begin
        rd_data <= mem[rd_addr];
    end

endmodule : ctr_flag_mem

/* testbench/ctr_tmem_model.sv */
// External table memory model, adjustable latency
module ctr_tmem_model
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // Read request and answer
    input  wire logic        tm_rd,
    input  wire logic [19:0] tm_addr,
    input  wire logic [1:0]  lat,
    output logic             tm_rvalid,
    output logic      [31:0] tm_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] mem [logic [19:0]];
    logic [19:0] addr_reg;
    logic [2:0]  wait_reg;
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            {tm_rvalid, tm_rdata, wait_reg, addr_reg} <= '0;
        else
        begin
            tm_rvalid <= 1'b0;
            // Stale word shown inverted
            tm_rdata <= ~tm_rdata;
            if (tm_rd)
            begin
                addr_reg <= tm_addr;
                wait_reg <= {1'b0, lat} + 3'h1;
            end
            else if (wait_reg == 3'h1)
            begin
                tm_rvalid <= 1'b1;
                // Unwritten: invalid record
                tm_rdata <= mem.exists(addr_reg) ? mem[addr_reg] : 32'hFFFF_FFFF;
                wait_reg <= 3'h0;
            end
            else if (wait_reg != 3'h0)
                wait_reg <= wait_reg - 3'h1;
        end
    end
endmodule : ctr_tmem_model

/* testbench/ctr_record_logic_monitor.sv */
// Port checker for lookup decode and flag access
module ctr_record_logic_monitor
(
    // Clock and reset
    input wire logic                           clk,
    input wire logic                           arst_n,
    // Configuration
    input wire logic [1:0]                     addr_compress_mode,
    input wire logic                           data_order_little,
    input wire logic [ctr_pkg::ADDR_W-1:0]     vp_table_base,
    input wire logic [ctr_pkg::ADDR_W-1:0]     vc_table_base,
    input wire logic [ctr_pkg::ADDR_W-1:0]     mc_table_base,
    // Lookup and table memory
    input wire logic                           lk_valid,
    input wire logic                           lk_ready,
    input wire ctr_pkg::ctr_lookup_req_t       lk_req,
    input wire logic                           tm_rd,
    input wire logic [ctr_pkg::ADDR_W-1:0]     tm_addr,
    input wire logic                           tm_rvalid,
    input wire logic [31:0]                    tm_rdata,
    input wire logic                           rs_valid,
    input wire ctr_pkg::ctr_lookup_rsp_t       rs_data,
    // Events and processor access
    input wire logic                           ev_valid,
    input wire ctr_pkg::ctr_cell_ev_t          ev_data,
    input wire logic                           ev_unknown,
    input wire logic                           hp_rd,
    input wire logic                           hp_rvalid,
    input wire logic [31:0]                    hp_rdata,
    input wire logic                           hp_busy
);
    ctr_pkg::ctr_lookup_req_t q_reg;
    logic [31:0] w0_reg, last_reg;
    logic        first_reg, need_vc;
    logic [15:0] idx, exp_conn;
    function automatic logic [15:0] pick(input logic [31:0] w, input logic odd);
        return (odd ^ data_order_little) ? w[15:0] : w[31:16];
    endfunction : pick
    function automatic logic [15:0] pext(input logic [15:0] v, input logic [15:0] m);
        logic [15:0] r;
        int n;
        r = 16'h0;
        n = 0;
        for (int i = 0; i < 16; i++)
        begin
            if (m[i])
            begin
                r[n] = v[i];
                n++;
            end
        end
        return r;
    endfunction : pext
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            {q_reg, first_reg, w0_reg, last_reg} <= '0;
        else
        begin
            if (lk_valid && lk_ready)
            begin
                q_reg <= lk_req;
                first_reg <= 1'b1;
            end
            if (tm_rvalid)
            begin
                last_reg <= tm_rdata;
                first_reg <= 1'b0;
                if (first_reg)
                    w0_reg <= tm_rdata;
            end
        end
    end
    always_comb
    begin
        idx = pext(q_reg.vci, w0_reg[15:0]);
        need_vc = !q_reg.multicast && !addr_compress_mode[0] && tm_rdata[31:16] != 16'hFFFF;
        if (q_reg.multicast)
            exp_conn = pick(last_reg, q_reg.mcast_id[0]);
        else if (addr_compress_mode[0])
            exp_conn = pick(last_reg, q_reg.vpi[0]);
        else if (w0_reg[31:16] == 16'hFFFF)
            exp_conn = last_reg[15:0];
        else
            exp_conn = pick(last_reg, idx[0]);
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_first_read_addr: assert property (lk_valid && lk_ready |=> tm_rd && tm_addr == (q_reg.multicast
        ? mc_table_base + 20'(q_reg.mcast_id[15:1]) : addr_compress_mode[0]
        ? vp_table_base + 20'(q_reg.vpi[11:1]) : vp_table_base + 20'(q_reg.vpi)))
        else $error("first table read at wrong address");
    a_vc_read_addr: assert property (tm_rd && !first_reg |->
        tm_addr == vc_table_base + 20'(w0_reg[31:16]) + 20'(idx[15:1]))
        else $error("sub-table read at wrong address");
    a_vc_read_time: assert property (tm_rvalid && first_reg && need_vc |=> tm_rd)
        else $error("sub-table read missing");
    a_answer_time: assert property (tm_rvalid && !(first_reg && need_vc) |=> rs_valid ##1 !rs_valid)
        else $error("lookup answer late or long");
    a_result_conn: assert property (rs_valid |-> rs_data.conn == exp_conn
        && rs_data.multicast == q_reg.multicast)
        else $error("lookup identifier wrong");
    a_unknown_flag: assert property (rs_valid |-> rs_data.unknown == (rs_data.conn == ctr_pkg::CONN_INVALID))
        else $error("unknown flag wrong");
    a_event_busy: assert property (ev_valid && !ev_unknown && ev_data.conn != 16'hFFFF |=> hp_busy)
        else $error("event did not start update");
    a_read_answer: assert property (hp_rd && !hp_busy |-> ##2 hp_rvalid)
        else $error("processor read not answered");
    a_reserved_zero: assert property (hp_rvalid |-> (hp_rdata & ~ctr_pkg::FLAG_USED_MASK) == 32'h0)
        else $error("reserved flag bits not zero");
    c_vc_read: cover property (tm_rd && !first_reg);
    c_invalid: cover property (rs_valid && rs_data.unknown);
    c_flag_set: cover property (hp_rvalid && hp_rdata != 32'h0);
endmodule : ctr_record_logic_monitor

bind ctr_record_logic ctr_record_logic_monitor mon_u (.*);

/* testbench/ctr_record_logic_tb.sv */
// Self-checking bench for the record logic
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; \
    $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module ctr_record_logic_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [19:0] VPB = 20'h10000, VCB = 20'h40000, MCB = 20'h80000;
    logic clk, arst_n, data_order_little, lk_valid, lk_ready, tm_rd, tm_rvalid, rs_valid;
    logic ev_valid, ev_unknown, hp_rd, hp_wr, hp_rvalid, hp_busy;
    logic [1:0]  addr_compress_mode, lat;
    logic [19:0] tm_addr;
    logic [31:0] tm_rdata, hp_wdata, hp_rdata, seed, rd_word, exp;
    logic [15:0] c, rec, m, ix;
    logic [7:0]  hp_addr;
    ctr_pkg::ctr_lookup_req_t lk_req, r;
    ctr_pkg::ctr_lookup_rsp_t rs_data, got;
    ctr_pkg::ctr_cell_ev_t    ev_data;
    int err_total = 0, compares = 0, cycles = 0;
    ctr_record_logic dut_u (.*, .vp_table_base(VPB), .vc_table_base(VCB), .mc_table_base(MCB));
    ctr_tmem_model mem_u (.*);
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [31:0] place(input logic [15:0] v, input logic odd, input logic little);
        return (odd == little) ? {v, ~v} : {~v, v};
    endfunction : place
    function automatic logic [15:0] gather(input logic [15:0] v, input logic [15:0] mk);
        gather = 16'h0;
        for (int i = 15; i >= 0; i--)
            if (mk[i])
                gather = {gather[14:0], v[i]};
    endfunction : gather
    function automatic logic [31:0] flags(input logic eg, input logic [2:0] k);
        logic [3:0] n;
        n = (k == 3'h0 || k == 3'h3) ? 4'h3 : (k == 3'h1) ? 4'h8 : (k == 3'h2) ? 4'h4 : (k == 3'h4) ? 4'h2 : 4'h0;
        return eg ? {n, 28'h0} : {16'h0, n, 12'h0};
    endfunction : flags
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    // Retried while an event update holds the port
    task automatic hp_access(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        hp_wr <= wr;
        hp_rd <= !wr;
        hp_addr <= a;
        hp_wdata <= d;
        do @(posedge clk); while (hp_busy !== 1'b0);
        hp_wr <= 1'b0;
        hp_rd <= 1'b0;
        while (!wr && hp_rvalid !== 1'b1 && n < 10)
        begin
            @(posedge clk);
            n++;
        end
        rd_word = hp_rdata;
    endtask : hp_access
    task automatic send_ev(input logic eg, input logic [2:0] k, input logic [15:0] cn, input logic u);
        @(posedge clk);
        ev_valid <= 1'b1;
        ev_data <= '{eg, ctr_pkg::ctr_cell_kind_t'(k), cn};
        ev_unknown <= u;
        @(posedge clk);
        ev_valid <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : send_ev
    task automatic lookup(input ctr_pkg::ctr_lookup_req_t q);
        int n = 0;
        @(posedge clk);
        lk_valid <= 1'b1;
        lk_req <= q;
        do @(posedge clk); while (lk_ready !== 1'b1);
        lk_valid <= 1'b0;
        while (rs_valid !== 1'b1 && n < 40)
        begin
            @(posedge clk);
            n++;
        end
        got = rs_data;
    endtask : lookup
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            report_and_stop();
        end
    end
    initial
    begin
        {arst_n, lk_valid, ev_valid, ev_unknown, hp_rd, hp_wr, data_order_little} = 7'h0;
        {addr_compress_mode, lat, hp_addr, hp_wdata, lk_req, ev_data} = '0;
        seed = 32'hD324;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        for (int a = 0; a < 256; a++)
            hp_access(1'b1, a[7:0], 32'h0);
        send_ev(1'b1, 3'h1, 16'hFFFF, 1'b0);
        hp_access(1'b0, 8'hFF, 32'h0);
        `CHK(rd_word, 32'h0)
        for (int t = 0; t < 4; t++)
        begin
            seed = lfsr(seed);
            c = {1'b0, seed[14:0]};
            exp = 32'h0;
            for (int k = 0; k < 6; k++)
            begin
                send_ev(t[0], k[2:0], c, 1'b0);
                exp |= flags(t[0], k[2:0]);
                hp_access(1'b0, c[7:0], 32'h0);
                `CHK(rd_word, exp)
            end
            send_ev(!t[0], 3'h1, c, 1'b1);
            hp_access(1'b0, c[7:0], 32'h0);
            `CHK(rd_word, exp)
            hp_access(1'b1, c[7:0], 32'hFFFF_FFFF);
            hp_access(1'b0, c[7:0], 32'h0);
            `CHK(rd_word, ctr_pkg::FLAG_USED_MASK)
            hp_access(1'b1, c[7:0], 32'h0);
            hp_access(1'b0, c[7:0], 32'h0);
            `CHK(rd_word, 32'h0)
        end
        $display("flag tests done");
        for (int i = 0; i < 32; i++)
        begin
            seed = lfsr(seed);
            addr_compress_mode <= i[1:0];
            data_order_little <= i[2];
            lat <= seed[31:30];
            r = {i % 5 == 4, seed[11:0], seed[27:12], seed[15:0]};
            seed = lfsr(seed);
            rec = (i % 7 == 3) ? 16'hFFFF : seed[15:0];
            m = (i == 6) ? 16'hFFFF : (i == 2) ? 16'h0 : seed[31:16];
            ix = gather(r.vci, m);
            // Records set up first
            if (r.multicast)
                mem_u.mem[MCB + r.mcast_id[15:1]] = place(rec, r.mcast_id[0], i[2]);
            else if (i[0])
                mem_u.mem[VPB + r.vpi[11:1]] = place(rec, r.vpi[0], i[2]);
            else if (i[3])
                mem_u.mem[VPB + r.vpi] = {16'hFFFF, rec};
            else
            begin
                mem_u.mem[VPB + r.vpi] = {1'b0, seed[14:0], m};
                mem_u.mem[VCB + seed[14:0] + ix[15:1]] = place(rec, ix[0], i[2]);
            end
            lookup(r);
            `CHK(got.conn, rec)
            `CHK(got.unknown, rec == 16'hFFFF)
        end
        $display("lookup tests done");
        report_and_stop();
    end
endmodule : ctr_record_logic_tb
